//--- hdl/bamsk_top.sv
// Analyzer capture config, write sequencer and framer 0-3 interrupt masks
module bamsk_top #(
  parameter int NUM_CHAN = bamsk_pkg::NUM_CHANNELS
) (
  // Clock, reset, enable
  input  wire logic                     mclk_i,
  input  wire logic                     reset_n_i,
  input  wire logic                     ce_i,
  // Microprocessor port
  input  wire bamsk_pkg::bamsk_cpu_req_t cpu_req_i,
  output logic [15:0]                   cpu_rdata_o,
  // Backplane timing and streams of all framers
  input  wire logic                     frame_start_i,
  input  wire logic                     chan_valid_i,
  input  wire logic [4:0]               chan_index_i,
  input  wire bamsk_pkg::bamsk_streams_t [7:0] streams_i,
  // Capture buffer write port
  output logic                          buf_wr_o,
  output logic [4:0]                    buf_addr_o,
  output logic [7:0]                    buf_data_o,
  output logic                          buf_full_o,
  // Per-framer summary interrupt sources and masked status
  input  wire logic [15:0]              irq_src_i,
  output logic [15:0]                   vector_status_o
);

  if (NUM_CHAN != 32) begin : g_chk
    $error("bamsk_top: buffer addressing needs NUM_CHAN of 32");
  end

  localparam logic [4:0] LAST_IDX = 5'(NUM_CHAN - 1);

  bamsk_pkg::bamsk_config_t     cfg_q;
  logic [15:0]                  mask_q;
  bamsk_pkg::bamsk_cap_state_t  state_q;
  bamsk_pkg::bamsk_cap_state_t  state_d;
  logic [4:0]                   ptr_q;
  logic [7:0]                   sel_byte;
  logic                         cfg_wr;
  logic                         take;
  logic                         last;

  // Byte of the chosen framer and stream in the current channel
  function automatic logic [7:0] pick_byte(
    input bamsk_pkg::bamsk_streams_t [7:0] s,
    input logic [2:0]                      framer,
    input logic [1:0]                      stream
  );
    bamsk_pkg::bamsk_streams_t f;
    f = s[framer];
    case (stream)
      bamsk_pkg::STREAM_DATA_IN:  pick_byte = f.serial_data_in;
      bamsk_pkg::STREAM_DATA_OUT: pick_byte = f.serial_data_out;
      bamsk_pkg::STREAM_SIG_IN:   pick_byte = f.signaling_in;
      default:                    pick_byte = f.signaling_out;
    endcase
  endfunction

  assign sel_byte = pick_byte(streams_i, cfg_q.capture_framer_select,
                              cfg_q.capture_stream_select);

  assign cfg_wr = cpu_req_i.cs && cpu_req_i.wr &&
                  (cpu_req_i.addr == bamsk_pkg::ADDR_CONFIG);

  // Register writes
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_q  <= bamsk_pkg::CONFIG_RESET;
      mask_q <= bamsk_pkg::MASK_RESET;
    end else if (ce_i && cpu_req_i.cs && cpu_req_i.wr) begin
      if (cpu_req_i.addr == bamsk_pkg::ADDR_CONFIG) begin
        cfg_q <= cpu_req_i.wdata & bamsk_pkg::CONFIG_WMASK;
      end
      if (cpu_req_i.addr == bamsk_pkg::ADDR_MASK) begin
        mask_q <= cpu_req_i.wdata;
      end
    end
  end

  // Register reads; unmapped addresses answer zero
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cpu_rdata_o <= 16'h0000;
    end else if (ce_i && cpu_req_i.cs && cpu_req_i.rd) begin
      case (cpu_req_i.addr)
        bamsk_pkg::ADDR_CONFIG: cpu_rdata_o <= cfg_q;
        bamsk_pkg::ADDR_MASK:   cpu_rdata_o <= mask_q;
        default:                cpu_rdata_o <= 16'h0000;
      endcase
    end
  end

  // A channel is taken in whole-frame mode always, else only when selected
  assign take = (state_q == bamsk_pkg::CAP_RUN) && chan_valid_i &&
                (cfg_q.whole_frame_capture ||
                 chan_index_i == cfg_q.capture_channel_select);
  assign last = cfg_q.whole_frame_capture ? (chan_index_i == LAST_IDX)
                                          : (ptr_q == LAST_IDX);

  always_comb begin
    state_d = state_q;
    case (state_q)
      bamsk_pkg::CAP_IDLE: begin
        state_d = bamsk_pkg::CAP_WAIT_FRAME;
      end
      bamsk_pkg::CAP_WAIT_FRAME: begin
        // Whole-frame capture must begin at channel zero
        if (frame_start_i) begin
          state_d = bamsk_pkg::CAP_RUN;
        end
      end
      bamsk_pkg::CAP_RUN: begin
        if (take && last) begin
          if (!cfg_q.capture_repeat) begin
            state_d = bamsk_pkg::CAP_DONE;
          end else if (cfg_q.whole_frame_capture) begin
            state_d = bamsk_pkg::CAP_WAIT_FRAME;
          end
        end
      end
      default: begin
        state_d = bamsk_pkg::CAP_DONE;
      end
    endcase
    // Clearing enable stops capture; any config write rearms single shot
    if (!cfg_q.capture_buffer_enable || cfg_wr) begin
      state_d = bamsk_pkg::CAP_IDLE;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= bamsk_pkg::CAP_IDLE;
    end else if (ce_i) begin
      state_q <= state_d;
    end
  end

  // Entry pointer for single-channel mode, one step per frame
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ptr_q <= 5'h00;
    end else if (ce_i) begin
      if (state_q != bamsk_pkg::CAP_RUN) begin
        ptr_q <= 5'h00;
      end else if (take && !cfg_q.whole_frame_capture) begin
        ptr_q <= ptr_q + 5'h01;
      end
    end
  end

  // Buffer write port; the full pulse rides on the last write
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      buf_wr_o   <= 1'b0;
      buf_addr_o <= 5'h00;
      buf_data_o <= 8'h00;
      buf_full_o <= 1'b0;
    end else if (ce_i) begin
      buf_wr_o   <= take && !cfg_wr && cfg_q.capture_buffer_enable;
      buf_full_o <= take && last && !cfg_wr;
      if (take) begin
        buf_addr_o <= cfg_q.whole_frame_capture ? chan_index_i
                                                : ptr_q;
        buf_data_o <= sel_byte;
      end
    end
  end

  // Summary status: masked bits held at zero, others follow the source
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vector_status_o <= 16'h0000;
    end else if (ce_i) begin
      vector_status_o <= irq_src_i & ~mask_q;
    end
  end

  // Checks

  // Address of the previous write, so the single-mode step is checked
  // against history rather than against the pointer that produced it
  logic [4:0]                   prev_addr_q;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_addr_q <= 5'h00;
    end else if (ce_i && buf_wr_o) begin
      prev_addr_q <= buf_addr_o;
    end
  end

  sequence s_full_single;
    buf_full_o && !cfg_q.capture_repeat;
  endsequence

  sequence s_quiet;
    !buf_wr_o [*8];
  endsequence

  AST_WR_NEEDS_ENABLE: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i || !ce_i)
    $rose(buf_wr_o) |-> $past(cfg_q.capture_buffer_enable))
    else $error("Buffer written while capture disabled");

  AST_SINGLE_CHAN: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i || !ce_i)
    (buf_wr_o && !$past(cfg_q.whole_frame_capture)) |->
      $past(chan_index_i) == $past(cfg_q.capture_channel_select))
    else $error("Single mode captured a wrong channel");

  AST_WHOLE_ADDR: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i || !ce_i)
    (buf_wr_o && $past(cfg_q.whole_frame_capture)) |->
      buf_addr_o == $past(chan_index_i))
    else $error("Whole frame entry at wrong address");

  AST_SOURCE_BYTE: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i || !ce_i)
    buf_wr_o |-> buf_data_o == $past(sel_byte))
    else $error("Captured byte not from selected source");

  AST_SINGLE_STEP: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i || !ce_i)
    (buf_wr_o && !$past(cfg_q.whole_frame_capture) &&
     buf_addr_o != 5'h00) |-> buf_addr_o == 5'(prev_addr_q + 5'h01))
    else $error("Single mode pointer did not step by one");

  AST_ONE_SHOT: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i || !ce_i || cfg_wr)
    s_full_single |=> s_quiet)
    else $error("Buffer refilled after single shot");

  AST_REPEAT: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i || !ce_i)
    (buf_full_o && cfg_q.capture_repeat) |->
      state_q != bamsk_pkg::CAP_DONE)
    else $error("Repeat capture stopped");

  AST_FULL_LAST: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i || !ce_i)
    buf_full_o |-> buf_wr_o && buf_addr_o == LAST_IDX)
    else $error("Full event not on last entry");

  AST_MASK_ZERO: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i || !ce_i)
    ##1 (vector_status_o & $past(mask_q)) == 16'h0000)
    else $error("Masked status bit is active");

  AST_UNMASK_FOLLOW: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i || !ce_i)
    ##1 (vector_status_o & ~$past(mask_q)) ==
        ($past(irq_src_i) & ~$past(mask_q)))
    else $error("Unmasked status does not follow source");

endmodule

//--- hdl/bamsk_pkg.sv
// Constants, field layouts and carrier types of the bus analyzer block
// Operation
// - Channel field picks captured backplane channel
// - Stream field picks data or signaling source
// - Buffer updates only while enable bit set
// - Framer field picks one of eight framers
// - Single-channel mode writes one entry per frame
// - Whole-frame mode writes every channel from zero
// - Repeat bit keeps refilling buffer continuously
// - Repeat clear fills buffer once then stops
// - Full buffer raises optional completion event
// - Set mask bit forces summary status zero
// - Clear mask bit lets summary status follow
package bamsk_pkg;

  localparam logic [11:0] ADDR_CONFIG = 12'h901;
  localparam logic [11:0] ADDR_MASK   = 12'h902;

  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET   = 16'h0000;
  // Bits 10-8 are unused: they store nothing and read as zero
  localparam logic [15:0] CONFIG_WMASK = 16'hf8ff;

  // Bit positions inside the config word
  localparam int CHAN_POS   = 11;
  localparam int STREAM_POS = 6;
  localparam int ENABLE_POS = 5;
  localparam int FRAMER_POS = 2;
  localparam int WHOLE_POS  = 1;
  localparam int REPEAT_POS = 0;

  localparam int MASK_BITS_PER_FRAMER = 4;
  localparam int NUM_MASKED_FRAMERS   = 4;
  localparam int NUM_FRAMERS          = 8;
  localparam int NUM_CHANNELS         = 32;

  localparam logic [1:0] STREAM_DATA_IN  = 2'h0;
  localparam logic [1:0] STREAM_DATA_OUT = 2'h1;
  localparam logic [1:0] STREAM_SIG_IN   = 2'h2;
  localparam logic [1:0] STREAM_SIG_OUT  = 2'h3;

  typedef struct packed {
    logic [4:0] capture_channel_select;
    logic [2:0] unused;
    logic [1:0] capture_stream_select;
    logic       capture_buffer_enable;
    logic [2:0] capture_framer_select;
    logic       whole_frame_capture;
    logic       capture_repeat;
  } bamsk_config_t;

  // Four backplane streams of one framer in the current channel
  typedef struct packed {
    logic [7:0] signaling_out;
    logic [7:0] signaling_in;
    logic [7:0] serial_data_out;
    logic [7:0] serial_data_in;
  } bamsk_streams_t;

  typedef struct packed {
    logic        cs;
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [15:0] wdata;
  } bamsk_cpu_req_t;

  typedef enum logic [1:0] {
    CAP_IDLE,
    CAP_WAIT_FRAME,
    CAP_RUN,
    CAP_DONE
  } bamsk_cap_state_t;

endpackage

//--- sim/bamsk_backplane.sv
// Backplane source: frame pulse, channel slots and per-framer stream bytes
module bamsk_backplane (
  // Clock, reset, run
  input  wire logic                        mclk_i,
  input  wire logic                        reset_n_i,
  input  wire logic                        run_i,
  // Backplane timing and streams
  output logic                             frame_start_o,
  output logic                             chan_valid_o,
  output logic [4:0]                       chan_index_o,
  output bamsk_pkg::bamsk_streams_t [7:0]  streams_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [6:0] cnt_q;

  // Frame of 65 cycles: pulse, then 32 slots two cycles apart
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      cnt_q <= 7'h00;
    else if (!run_i)
      cnt_q <= 7'h00;
    else
      cnt_q <= (cnt_q == 7'h40) ? 7'h00 : cnt_q + 7'h01;
  end

  assign frame_start_o = run_i && (cnt_q == 7'h00);
  assign chan_valid_o  = run_i && cnt_q[0];
  assign chan_index_o  = cnt_q[5:1];

  // Outside a slot the bytes are inverted so stale data never looks valid
  always_comb begin
    for (int f = 0; f < 8; f++) begin
      for (int s = 0; s < 4; s++) begin
        streams_o[f][s*8 +: 8] = {3'(f), chan_index_o} ^ 8'(s * 64)
                                 ^ {8{!chan_valid_o}};
      end
    end
  end
endmodule

//--- sim/bamsk_top_tb.sv
// Self-checking bench of the analyzer config, capture and interrupt masks
module bamsk_top_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic                            mclk_i = 1'b0;
  logic                            reset_n_i = 1'b0;
  logic                            run = 1'b0;
  logic                            ce = 1'b1;
  bamsk_pkg::bamsk_cpu_req_t       cpu_req = '0;
  logic [15:0]                     irq_src = 16'h0000;
  logic [15:0]                     rdata;
  logic [15:0]                     vstat;
  logic                            fs, cv, wr, full;
  logic [4:0]                      ci, wa;
  logic [7:0]                      wd, exp_d;
  bamsk_pkg::bamsk_streams_t [7:0] st;
  bamsk_pkg::bamsk_config_t        cfg = '0;
  int                              err_total = 0;
  int                              samples_checked = 0;
  int                              wcnt = 0;
  int                              cyc = 0;

  bamsk_top i_bamsk_top (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .ce_i(ce), .cpu_req_i(cpu_req), .cpu_rdata_o(rdata),
    .frame_start_i(fs), .chan_valid_i(cv), .chan_index_i(ci),
    .streams_i(st), .buf_wr_o(wr), .buf_addr_o(wa), .buf_data_o(wd),
    .buf_full_o(full), .irq_src_i(irq_src), .vector_status_o(vstat));

  bamsk_backplane i_bamsk_backplane (.mclk_i(mclk_i),
    .reset_n_i(reset_n_i), .run_i(run), .frame_start_o(fs),
    .chan_valid_o(cv), .chan_index_o(ci), .streams_o(st));

  initial forever #50 mclk_i = ~mclk_i;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // Requests are held across one sampling edge, then a quiet cycle
  task automatic reg_wr(logic [11:0] a, logic [15:0] d);
    cpu_req = '{1'b1, 1'b1, 1'b0, a, d};
    @(posedge mclk_i) #1;
    cpu_req = '0;
    @(posedge mclk_i) #1;
  endtask

  task automatic reg_rd(logic [11:0] a, logic [15:0] exp);
    cpu_req = '{1'b1, 1'b0, 1'b1, a, 16'h0000};
    @(posedge mclk_i) #1;
    cpu_req = '0;
    @(posedge mclk_i) #1;
    check("read data", exp, rdata);
  endtask

  // Backplane is stopped while configuring, so exactly n frames are seen
  task automatic capture(bamsk_pkg::bamsk_config_t c, int n, int exp);
    reg_wr(bamsk_pkg::ADDR_CONFIG, 16'h0000);
    cfg = c;
    wcnt = 0;
    reg_wr(bamsk_pkg::ADDR_CONFIG, c);
    repeat (3) @(posedge mclk_i);
    #1 run = 1'b1;
    repeat (n * 65) @(posedge mclk_i);
    #1 run = 1'b0;
    repeat (3) @(posedge mclk_i);
    #1 check("write count", 16'(exp), 16'(wcnt));
  endtask

  // Sampled on the falling edge, away from the edge that launches them
  always @(negedge mclk_i) begin
    if (wr === 1'b1) begin
      exp_d = {cfg.capture_framer_select, cfg.whole_frame_capture ?
               wcnt[4:0] : cfg.capture_channel_select}
              ^ {cfg.capture_stream_select, 6'h00};
      check("buf addr", 16'(wcnt % 32), 16'(wa));
      check("buf data", 16'(exp_d), 16'(wd));
      check("buf full", 16'(wcnt % 32 == 31), 16'(full));
      wcnt++;
    end
    cyc++;
    if (cyc > 10000) begin
      err_total++;
      finish_test();
    end
  end

  initial begin
    repeat (6) @(posedge mclk_i);
    #1 reset_n_i = 1'b1;
    reg_rd(bamsk_pkg::ADDR_CONFIG, bamsk_pkg::CONFIG_RESET);
    reg_rd(bamsk_pkg::ADDR_MASK, bamsk_pkg::MASK_RESET);
    reg_wr(bamsk_pkg::ADDR_CONFIG, 16'hffff);
    reg_rd(bamsk_pkg::ADDR_CONFIG, 16'hf8ff);
    reg_wr(12'h903, 16'hffff);
    reg_rd(12'h903, 16'h0000);
    reg_rd(bamsk_pkg::ADDR_MASK, 16'h0000);
    irq_src = 16'hffff;
    reg_wr(bamsk_pkg::ADDR_MASK, 16'h5a3c);
    reg_rd(bamsk_pkg::ADDR_MASK, 16'h5a3c);
    check("status", 16'ha5c3, vstat);
    irq_src = 16'h0f0f;
    repeat (2) @(posedge mclk_i);
    #1 check("status", 16'h0503, vstat);
    // A write while the clock enable is low must leave the mask alone
    ce = 1'b0;
    reg_wr(bamsk_pkg::ADDR_MASK, 16'hffff);
    ce = 1'b1;
    reg_rd(bamsk_pkg::ADDR_MASK, 16'h5a3c);
    check("status", 16'h0503, vstat);
    for (int s = 0; s < 4; s++)
      capture('{5'h00, 3'h0, 2'(s), 1'b1, 3'(s*2+1), 1'b1, 1'b0}, 2, 32);
    capture('{5'h00, 3'h0, 2'h1, 1'b1, 3'h6, 1'b1, 1'b1}, 2, 64);
    capture('{5'h00, 3'h0, 2'h0, 1'b0, 3'h2, 1'b1, 1'b1}, 1, 0);
    capture('{5'h1f, 3'h0, 2'h3, 1'b1, 3'h4, 1'b0, 1'b1}, 34, 34);
    capture('{5'h00, 3'h0, 2'h2, 1'b1, 3'h7, 1'b0, 1'b0}, 33, 32);
    finish_test();
  end
endmodule
